// ==== hw/solenoid_modes.sv ====
// mode logic, input filtering and boost timing of the two-channel solenoid driver
`timescale 1ns/1ps
`default_nettype none

module solenoid_modes #(
  parameter int MS_CYCLES = solenoid_pkg::MS_CYCLES_DFLT,   // cycles per ms
  parameter int FILT_CYCLES = solenoid_pkg::FILT_CYCLES_DFLT // filter settle
) (
  input wire logic mclk,                          // system clock
  input wire logic rstn,                          // async reset, active low
  input wire logic [3:0] selector,                // rotary code switch
  input wire solenoid_pkg::ctl_in_t ctl_in,       // control inputs, high = one
  output var solenoid_pkg::drive_t drive          // coils and boost pulses
);
  import solenoid_pkg::*;

  // ==========================================================
  // decode functions
  // both are used by the mode logic and the pulse timer, so the
  // decode lives in one place and cannot drift between the two

  // mode from the low selector bits
  // positions 4 to 7 all fold onto the latched pulse mode
  function automatic mode_t decode_mode(input logic [2:0] s);
    mode_t m;
    m = MODE_TIMED;
    case (s)
      3'h0: m = MODE_DIRECT;
      3'h1: m = MODE_GATED;
      3'h2: m = MODE_CHANGE;
      3'h3: m = MODE_LATCH;
      default: m = MODE_TIMED;
    endcase
    return m;
  endfunction : decode_mode

  // pulse length in ms for the active mode
  // mode 2 reads input 4 only, as input 3 is its enable there
  function automatic logic [4:0] pulse_ms(input mode_t m, input logic [2:0] s,
                                          input ctl_in_t c);
    logic [4:0] p;
    p = PULSE_1MS;
    case (m)
      MODE_GATED: p = c.in4 ? PULSE_5MS : PULSE_2MS;
      MODE_TIMED: begin
        // mode 5 takes its length from the selector
        case (s[1:0])
          2'h0: p = PULSE_1MS;
          2'h1: p = PULSE_2MS;
          2'h2: p = PULSE_5MS;
          default: p = PULSE_10MS;
        endcase
      end
      default: begin
        case ({c.in4, c.in3})
          2'h0: p = PULSE_1MS;
          2'h1: p = PULSE_2MS;
          2'h2: p = PULSE_5MS;
          default: p = PULSE_10MS;
        endcase
      end
    endcase
    return p;
  endfunction : pulse_ms

  // ==========================================================
  // selector synchroniser
  logic [3:0] sel_meta; // first stage, read only by sel_sync
  logic [3:0] sel_sync; // settled selector
  logic [3:0] next_sel_meta;
  logic [3:0] next_sel_sync;

  // the switch can move at any time; two stages keep it clean
  // limitation: the selector is not debounced, so turning the switch
  // while coils are driven may pass through neighbouring modes briefly
  always_comb begin
    next_sel_meta = selector;
    next_sel_sync = sel_meta;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_meta <= 4'h0;
      sel_sync <= 4'h0;
    end else begin
      sel_meta <= next_sel_meta;
      sel_sync <= next_sel_sync;
    end
  end

  logic filt_en; // filtering requested by selector bit 3
  mode_t mode;   // active switching mode
  assign filt_en = sel_sync[SEL_FILT_BIT];
  assign mode = decode_mode(sel_sync[SEL_MODE_W-1:0]);

  // ==========================================================
  // input synchroniser and interference filter, one per input
  // each input has its own counter, so a noisy line cannot hold back
  // a clean one
  logic [3:0] in_filt; // inputs as the mode logic sees them

  for (genvar i = 0; i < 4; i++) begin : g_in
    logic meta;                // first stage, read only by sync
    logic sync;                // synchronised input
    logic filt;                // accepted level
    logic [FILT_W-1:0] cnt;    // cycles the new level has held
    logic next_meta;
    logic next_sync;
    logic next_filt;
    logic [FILT_W-1:0] next_cnt;

    // a change must hold for the whole filter time to be taken;
    // a relay bounce restarts the count, which is the intended cost
    // with filtering off the counter is held at zero, so turning the
    // filter on later never inherits a stale count
    always_comb begin
      next_meta = ctl_in[i];
      next_sync = meta;
      next_filt = filt;
      next_cnt = '0;
      if (!filt_en) begin
        next_filt = sync;
      end else if (sync != filt) begin
        if (cnt == FILT_W'(FILT_CYCLES - 1)) begin
          next_filt = sync;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        meta <= 1'b0;
        sync <= 1'b0;
        filt <= 1'b0;
        cnt <= '0;
      end else begin
        meta <= next_meta;
        sync <= next_sync;
        filt <= next_filt;
        cnt <= next_cnt;
      end
    end

    assign in_filt[i] = filt;
  end

  ctl_in_t in_c;       // filtered inputs as a struct
  logic [4:0] p_ms;    // selected pulse length
  logic [TMR_W-1:0] p_cyc; // selected pulse length in cycles
  assign in_c = ctl_in_t'(in_filt);
  assign p_ms = pulse_ms(mode, sel_sync[SEL_MODE_W-1:0], in_c);
  // the product is cut to the timer width on purpose: TMR_W leaves room
  // for twice the longest pulse, which the doubled pause needs
  assign p_cyc = TMR_W'(int'(p_ms) * MS_CYCLES);

  // ==========================================================
  // mode logic: coil levels, latch and changeover sequencer
  logic [1:0] coil;        // coil drive register
  logic latch;             // mode 4 set/reset memory
  change_t co_state;       // changeover sequencer
  logic [TMR_W-1:0] pause; // remaining pause cycles
  logic [1:0] next_coil;
  logic next_latch;
  change_t next_co_state;
  logic [TMR_W-1:0] next_pause;

  // in mode 3 one coil is released before the other is driven, so a
  // double coil never sees both windings at once there
  // leaving mode 3 drops a pause in progress; the latch of mode 4 is
  // written only in that mode and keeps its value across the others
  always_comb begin
    next_coil = coil;
    next_latch = latch;
    next_co_state = CO_IDLE;
    next_pause = '0;
    case (mode)
      MODE_DIRECT: begin
        next_coil = {in_c.in2, in_c.in1};
      end
      MODE_GATED: begin
        // enable low forces both coils off
        next_coil = in_c.in3 ? {in_c.in2, in_c.in1} : 2'h0;
      end
      MODE_CHANGE: begin
        next_co_state = co_state;
        next_pause = pause;
        case (co_state)
          CO_IDLE: begin
            // steady state reached: nothing to do
            if (coil != {~in_c.in1, in_c.in1}) begin
              next_coil = 2'h0;
              // low input 2 doubles the pause
              next_pause = in_c.in2 ? p_cyc : TMR_W'({p_cyc, 1'b0});
              next_co_state = CO_PAUSE;
            end
          end
          CO_PAUSE: begin
            if (pause <= TMR_W'(1)) begin
              // drive the coil that the input asks for now
              next_coil = {~in_c.in1, in_c.in1};
              next_co_state = CO_IDLE;
              next_pause = '0;
            end else begin
              next_pause = pause - 1'b1;
            end
          end
          default: begin
            next_co_state = CO_IDLE;
          end
        endcase
      end
      MODE_LATCH: begin
        if (!in_c.in2) begin
          next_latch = 1'b0;
        end else if (in_c.in1) begin
          next_latch = 1'b1;
        end
        // with input 2 high and input 1 low the latch keeps its value
        next_coil = {~next_latch, next_latch};
      end
      default: begin
        // latched pulse mode is not built here: coils stay off
        next_coil = 2'h0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      coil <= RST_COIL;
      latch <= RST_LATCH;
      co_state <= CO_IDLE;
      pause <= '0;
    end else begin
      coil <= next_coil;
      latch <= next_latch;
      co_state <= next_co_state;
      pause <= next_pause;
    end
  end

  // ==========================================================
  // boost pulse timer, one per coil
  logic [1:0] boost; // boost pulse registers

  for (genvar k = 0; k < 2; k++) begin : g_boost
    logic [TMR_W-1:0] tmr; // remaining boost cycles
    logic b;               // boost active
    logic [TMR_W-1:0] next_tmr;
    logic next_b;

    // the timer loads in the same cycle the coil turns on, so the pulse
    // starts with the coil; switching off cuts the pulse short
    // the length is taken at switch-on, so moving inputs 3 and 4 while
    // a pulse runs only affects the next one
    always_comb begin
      next_tmr = '0;
      if (next_coil[k] && !coil[k]) begin
        next_tmr = p_cyc;
      end else if (next_coil[k] && tmr != '0) begin
        next_tmr = tmr - 1'b1;
      end
      next_b = next_tmr != '0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        tmr <= '0;
        b <= RST_BOOST[k];
      end else begin
        tmr <= next_tmr;
        b <= next_b;
      end
    end

    assign boost[k] = b;
  end

  // ==========================================================
  // outputs, both fields straight from registers
  // no logic sits between the registers and the pins, so the coil
  // drivers never see a combinational glitch
  assign drive.coil = coil;
  assign drive.boost = boost;

endmodule : solenoid_modes

`default_nettype wire

// ==== inc/solenoid_pkg.sv ====
// shared types and constants of the two-channel solenoid boost mode logic
package solenoid_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 100_000_000;           // mclk rate
  localparam int CYC_PER_US = CLK_HZ / 1_000_000; // cycles per microsecond
  localparam int MS_TIME_US = 1000;              // one millisecond, in us
  localparam int MS_CYCLES_DFLT = MS_TIME_US * CYC_PER_US;
  localparam int FILT_TIME_US = 1000;            // input filter settle time, in us
  localparam int FILT_CYCLES_DFLT = FILT_TIME_US * CYC_PER_US;
  localparam int TMR_W = 22;                     // holds 20 ms of cycles
  localparam int FILT_W = 18;                    // holds the filter count

  // ==========================================================
  // pulse lengths in milliseconds
  localparam logic [4:0] PULSE_1MS = 5'h01;
  localparam logic [4:0] PULSE_2MS = 5'h02;
  localparam logic [4:0] PULSE_5MS = 5'h05;
  localparam logic [4:0] PULSE_10MS = 5'h0A;

  // ==========================================================
  // selector fields
  localparam int SEL_FILT_BIT = 3;               // high selector bit: filter on
  localparam int SEL_MODE_W = 3;                 // low selector bits: mode

  // ==========================================================
  // reset values
  localparam logic RST_LATCH = 1'b0;             // latch starts reset
  localparam logic [1:0] RST_COIL = 2'h0;        // coils off
  localparam logic [1:0] RST_BOOST = 2'h0;       // no boost

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    MODE_DIRECT, MODE_GATED, MODE_CHANGE, MODE_LATCH, MODE_TIMED
  } mode_t;

  typedef enum logic [0:0] {CO_IDLE, CO_PAUSE} change_t;

  typedef struct packed {
    logic in4;
    logic in3;
    logic in2;
    logic in1;
  } ctl_in_t;

  typedef struct packed {
    logic [1:0] boost;   // overexcitation pulse per coil
    logic [1:0] coil;    // coil drive, bit 0 is output 1
  } drive_t;

endpackage : solenoid_pkg

// ==== tb/solenoid_sva.sv ====
// port assertions of the solenoid mode logic
`timescale 1ns/1ps
`default_nettype none
module solenoid_sva #(
  parameter int MS_CYCLES = solenoid_pkg::MS_CYCLES_DFLT // cycles per ms
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] selector,
  input wire solenoid_pkg::ctl_in_t ctl_in,
  input wire solenoid_pkg::drive_t drive
);
  import solenoid_pkg::*;
  // ==========================================
  // helper: cycles the boost of coil 1 has run
  int unsigned blen; // current run length
  int unsigned next_blen; // next run length
  always_comb next_blen = drive.boost[0] ? blen + 1 : 0;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) blen <= 0;
    else blen <= next_blen;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // assertions; six steady cycles cover the four-stage input path
  AST_BOOST_ON_COIL: assert property ((drive.boost & ~drive.coil) == 2'h0)
    else $error("boost without coil");
  AST_BOOST_AT_ON: assert property ($rose(drive.coil[0]) |-> drive.boost[0])
    else $error("no boost at switch-on");
  AST_BOOST_MAX: assert property (blen <= 10 * MS_CYCLES)
    else $error("boost too long");
  AST_BOOST_LEN: assert property ($fell(drive.boost[0]) && drive.coil[0] |->
    blen inside {MS_CYCLES, 2 * MS_CYCLES, 5 * MS_CYCLES, 10 * MS_CYCLES})
    else $error("boost length off");
  AST_MODE1: assert property ((selector == 4'h0 && $stable(ctl_in)) [*6] |->
    drive.coil == {ctl_in.in2, ctl_in.in1})
    else $error("pass-through wrong");
  AST_MODE2: assert property ((selector == 4'h1 && $stable(ctl_in)) [*6] |->
    drive.coil == (ctl_in.in3 ? {ctl_in.in2, ctl_in.in1} : 2'h0))
    else $error("gated pass wrong");
  AST_MODE3_EXCL: assert property (selector == 4'h2 [*5] |-> drive.coil != 2'h3)
    else $error("both coils on");
  AST_MODE4_RST: assert property ((selector == 4'h3 && !ctl_in.in2) [*6] |-> drive.coil == 2'h2)
    else $error("reset not dominant");
  AST_MODE4_SET: assert property ((selector == 4'h3 && ctl_in.in1 && ctl_in.in2) [*6] |->
    drive.coil == 2'h1)
    else $error("set failed");
  AST_MODE4_HOLD: assert property ((selector == 4'h3 && ctl_in.in2 && !ctl_in.in1) [*6] |->
    $stable(drive.coil))
    else $error("latch not held");
  AST_MODE5_OFF: assert property (selector[2] [*5] |-> drive.coil == 2'h0)
    else $error("coil on in mode 5");
  C_PAUSE: cover property ($fell(drive.coil[1]) ##[1:400] $rose(drive.coil[0]));
  C_BOOST: cover property ($fell(drive.boost[1]));
  C_FILT: cover property (selector[3] && $rose(drive.coil[0]));
endmodule : solenoid_sva
bind solenoid_modes solenoid_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.mclk(mclk), .rstn(rstn),
  .selector(selector), .ctl_in(ctl_in), .drive(drive));
`default_nettype wire

// ==== tb/coil_load.sv ====
// load model: coils that report the length of the last boost
`timescale 1ns/1ps
`default_nettype none
module coil_load (
  input wire logic mclk,
  input wire solenoid_pkg::drive_t drive,
  output var int last_len
);
  int run = 0; // cycles of overvoltage so far
  int len = 0; // length of the last finished run
  assign last_len = len;
  // ==========================================
  // length is taken once the overvoltage ends
  always @(posedge mclk) begin
    if (|drive.boost) run <= run + 1;
    else if (run != 0) begin
      len <= run;
      run <= 0;
    end
  end
endmodule : coil_load
`default_nettype wire

// ==== tb/solenoid_modes_bench.sv ====
// self-checking bench of the solenoid mode logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module solenoid_modes_bench;
  import solenoid_pkg::*;
  localparam int M = 20; // short ms keeps the run brief
  localparam int F = 8; // short filter settle
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] selector = 4'h0;
  ctl_in_t ctl_in = '0;
  drive_t drive;
  int last_len, num_errors = 0, samples_checked = 0, wt, n;
  int plen[4] = '{1, 2, 5, 10}; // pulse ms by {in4,in3}
  always #5 mclk = ~mclk;
  solenoid_modes #(.MS_CYCLES(M), .FILT_CYCLES(F)) dut (.mclk(mclk), .rstn(rstn),
    .selector(selector), .ctl_in(ctl_in), .drive(drive));
  coil_load load (.mclk(mclk), .drive(drive), .last_len(last_len));
  // ==========================================
  // drive selector and inputs at a falling edge, then wait k cycles
  task automatic put(input logic [3:0] s, input logic [3:0] c, input int k);
    @(negedge mclk);
    selector = s;
    ctl_in = c;
    repeat (k) @(negedge mclk);
  endtask : put
  // wait for a drive pattern (bounded), then count how long it lasts
  task automatic run_len(input logic [3:0] pat, output int w, output int len);
    w = 0;
    len = 0;
    while (drive !== pat && w < 1000) begin @(negedge mclk); w++; end
    while (drive === pat && len < 1000) begin @(negedge mclk); len++; end
  endtask : run_len
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // ==========================================
  // watchdog: the tests take some 2100 cycles
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // ==========================================
  // tests
  initial begin
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    put(4'h3, 4'h2, 8);
    `CHK("latch start", 2'h2, drive.coil)
    put(4'h3, 4'h3, 8);
    `CHK("latch set", 2'h1, drive.coil)
    put(4'h3, 4'h2, 8);
    `CHK("latch hold", 2'h1, drive.coil)
    put(4'h3, 4'h1, 8);
    `CHK("latch reset", 2'h2, drive.coil)
    put(4'h3, 4'h2, 8);
    `CHK("hold after reset", 2'h2, drive.coil)
    $display("test latch done");
    for (int i = 0; i < 4; i++) begin
      put(4'h0, {i[1:0], 2'b00}, 8);
      put(4'h0, {i[1:0], 2'b01}, 0);
      run_len(4'h5, wt, n);
      `CHK("direct latency", 4, wt)
      `CHK("pulse mode 1", plen[i] * M, n)
    end
    $display("test direct done");
    for (int j = 0; j < 2; j++) begin
      put(4'h1, {j[0], 3'b100}, 8);
      put(4'h1, {j[0], 3'b110}, 0);
      run_len(4'hA, wt, n);
      `CHK("gated latency", 4, wt)
      @(negedge mclk);
      `CHK("pulse mode 2", (j ? 5 : 2) * M, last_len)
    end
    put(4'h1, 4'h3, 8);
    `CHK("gate off", 2'h0, drive.coil)
    $display("test gated done");
    for (int j = 0; j < 2; j++) begin
      put(4'h2, {3'b000, j[0]} << 1, 500);
      `CHK("mode 3 idle", 2'h2, drive.coil)
      put(4'h2, ({3'b000, j[0]} << 1) | 4'h1, 0);
      run_len(4'h0, wt, n);
      `CHK("changeover start", 4, wt)
      `CHK("pause", (j ? 1 : 2) * M, n)
      run_len(4'h5, wt, n);
      `CHK("boost after pause", M, n)
      `CHK("mode 3 on", 2'h1, drive.coil)
    end
    $display("test changeover done");
    put(4'h8, 4'h0, 30);
    put(4'h8, 4'h1, 3);
    put(4'h8, 4'h0, 20);
    `CHK("glitch ignored", 2'h0, drive.coil)
    put(4'h8, 4'h1, 0);
    run_len(4'h5, wt, n);
    `CHK("filter latency", 1'b1, wt >= F + 2 && wt <= F + 6)
    $display("test filter done");
    // reset in mid-run: the latch must come back in its reset state
    put(4'h3, 4'h3, 8);
    `CHK("set before reset", 2'h1, drive.coil)
    ctl_in = 4'h2;
    rstn = 1'b0;
    @(negedge mclk);
    `CHK("drive in reset", 4'h0, drive)
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK("latch after reset", 2'h2, drive.coil)
    $display("test reset done");
    for (int s = 4; s < 16; s++) begin
      if (s[2]) begin
        put(s[3:0], 4'h3, 30);
        `CHK("mode 5 off", 4'h0, drive)
      end
    end
    $display("test mode5 done");
    end_sim();
  end
endmodule : solenoid_modes_bench
`default_nettype wire
